/* hdl/spmr_pkg.sv */
// Package: offsets, field positions, reset values and carriers for the PMA settings bank
package spmr_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFF_ARB = 12'h000;
  localparam logic [11:0] OFF_CAL = 12'h100;
  localparam logic [11:0] OFF_POST1 = 12'h105;
  localparam logic [11:0] OFF_POST2 = 12'h106;
  localparam logic [11:0] OFF_PRE1 = 12'h107;
  localparam logic [11:0] OFF_PRE2 = 12'h108;
  localparam logic [11:0] OFF_SWING = 12'h109;
  localparam logic [11:0] OFF_LB5 = 12'h11D;
  localparam logic [11:0] OFF_LB43 = 12'h132;
  localparam logic [11:0] OFF_LB2 = 12'h137;
  localparam logic [11:0] OFF_LB1 = 12'h13C;
  localparam logic [11:0] OFF_LB0 = 12'h142;
  localparam logic [11:0] OFF_BWSRC = 12'h166;

  // ==========================================================
  // Writable bit masks per address
  localparam logic [7:0] MASK_ARB = 8'h01;
  localparam logic [7:0] MASK_CAL = 8'h0B;
  localparam logic [7:0] MASK_POST1 = 8'h5F;
  localparam logic [7:0] MASK_POST2 = 8'h2F;
  localparam logic [7:0] MASK_PRE1 = 8'h3F;
  localparam logic [7:0] MASK_PRE2 = 8'h17;
  localparam logic [7:0] MASK_SWING = 8'h3F;
  localparam logic [7:0] MASK_LB5 = 8'h01;
  localparam logic [7:0] MASK_LB43 = 8'h30;
  localparam logic [7:0] MASK_LB2 = 8'h80;
  localparam logic [7:0] MASK_LB1 = 8'h80;
  localparam logic [7:0] MASK_LB0 = 8'h10;
  localparam logic [7:0] MASK_BWSRC = 8'h80;

  // ==========================================================
  // Field positions
  localparam int unsigned ARB_BIT = 0;
  localparam int unsigned DONE_BIT = 1;
  localparam int unsigned RXCAL_BIT = 0;
  localparam int unsigned TXCAL_BIT = 1;
  localparam int unsigned PREP_BIT = 3;
  localparam int unsigned POST1_SIGN_BIT = 6;
  localparam int unsigned POST2_SIGN_BIT = 5;
  localparam int unsigned PRE1_SIGN_BIT = 5;
  localparam int unsigned PRE2_SIGN_BIT = 4;
  localparam int unsigned COMP_BIT = 5;
  localparam int unsigned LB5_BIT = 0;
  localparam int unsigned LB43_LSB = 4;
  localparam int unsigned LB2_BIT = 7;
  localparam int unsigned LB1_BIT = 7;
  localparam int unsigned LB0_BIT = 4;
  localparam int unsigned BWSRC_BIT = 7;

  // ==========================================================
  // Reset value and loopback codes
  localparam logic [7:0] RESET_VAL = 8'h00;
  localparam logic [5:0] LB_OFF = 6'h00;
  localparam logic [5:0] LB_DIAG = 6'h25;
  localparam logic [5:0] LB_POST = 6'h0A;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [4:0] post1_mag;
    logic post1_neg;
    logic [3:0] post2_mag;
    logic post2_neg;
    logic [4:0] pre1_mag;
    logic pre1_neg;
    logic [2:0] pre2_mag;
    logic pre2_neg;
    logic [4:0] swing;
    logic hs_comp;
  } spmr_tx_s;

  typedef struct packed {
    logic user_owns_bus;
    logic engine_owns_bus;
    logic rx_cal_en;
    logic tx_cal_en;
    logic reconfig_req;
    logic bw_from_default;
  } spmr_cal_s;

  typedef struct packed {
    logic [5:0] sel;
    logic diag_rev;
    logic post_rev;
  } spmr_lb_s;

endpackage : spmr_pkg

/* hdl/spmr_regs.sv */
// Per-channel PMA settings register bank
`timescale 1ns/1ps
// ==========================================================
module spmr_regs
  import spmr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // Calibration engine status
  input wire logic cal_busy,
  // Analogue controls
  output spmr_tx_s tx_ctrl,
  output spmr_cal_s cal_ctrl,
  output spmr_lb_s lb_ctrl
);

  // ==========================================================
  // Storage, one byte per mapped address
  logic [7:0] arb_q, cal_q, post1_q, post2_q, pre1_q, pre2_q, swing_q;
  logic [7:0] lb5_q, lb43_q, lb2_q, lb1_q, lb0_q, bwsrc_q;
  logic [7:0] rdata_q;

  // ==========================================================
  // Elaboration checks
  // Field positions assume byte-wide data and twelve-bit offsets;
  // another geometry would need a new map, not just new widths
  if (DATA_W != 8 || ADDR_W != 12) begin : g_geom_check
    $error("register bank needs byte data and twelve-bit addresses");
  end

  // Merge written data into writable bits only; other bits stay zero
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] wd,
                                       input logic hit, input logic [7:0] mask);
    merge = hit ? (wd & mask) : old_v;
  endfunction : merge

  // ==========================================================
  // Address decode
  wire logic hit_arb = reg_write && (reg_addr == OFF_ARB);
  wire logic hit_cal = reg_write && (reg_addr == OFF_CAL);
  wire logic hit_post1 = reg_write && (reg_addr == OFF_POST1);
  wire logic hit_post2 = reg_write && (reg_addr == OFF_POST2);
  wire logic hit_pre1 = reg_write && (reg_addr == OFF_PRE1);
  wire logic hit_pre2 = reg_write && (reg_addr == OFF_PRE2);
  wire logic hit_swing = reg_write && (reg_addr == OFF_SWING);
  wire logic hit_lb5 = reg_write && (reg_addr == OFF_LB5);
  wire logic hit_lb43 = reg_write && (reg_addr == OFF_LB43);
  wire logic hit_lb2 = reg_write && (reg_addr == OFF_LB2);
  wire logic hit_lb1 = reg_write && (reg_addr == OFF_LB1);
  wire logic hit_lb0 = reg_write && (reg_addr == OFF_LB0);
  wire logic hit_bwsrc = reg_write && (reg_addr == OFF_BWSRC);

  // ==========================================================
  // Register writes
  // Masked field update
  always_ff @(posedge clock) begin
    if (reset) begin
      arb_q <= RESET_VAL;
      cal_q <= RESET_VAL;
      post1_q <= RESET_VAL;
      post2_q <= RESET_VAL;
      pre1_q <= RESET_VAL;
      pre2_q <= RESET_VAL;
      swing_q <= RESET_VAL;
      lb5_q <= RESET_VAL;
      lb43_q <= RESET_VAL;
      lb2_q <= RESET_VAL;
      lb1_q <= RESET_VAL;
      lb0_q <= RESET_VAL;
      bwsrc_q <= RESET_VAL;
    end else begin
      arb_q <= merge(arb_q, reg_wdata, hit_arb, MASK_ARB);
      cal_q <= merge(cal_q, reg_wdata, hit_cal, MASK_CAL);
      post1_q <= merge(post1_q, reg_wdata, hit_post1, MASK_POST1);
      post2_q <= merge(post2_q, reg_wdata, hit_post2, MASK_POST2);
      pre1_q <= merge(pre1_q, reg_wdata, hit_pre1, MASK_PRE1);
      pre2_q <= merge(pre2_q, reg_wdata, hit_pre2, MASK_PRE2);
      swing_q <= merge(swing_q, reg_wdata, hit_swing, MASK_SWING);
      lb5_q <= merge(lb5_q, reg_wdata, hit_lb5, MASK_LB5);
      lb43_q <= merge(lb43_q, reg_wdata, hit_lb43, MASK_LB43);
      lb2_q <= merge(lb2_q, reg_wdata, hit_lb2, MASK_LB2);
      lb1_q <= merge(lb1_q, reg_wdata, hit_lb1, MASK_LB1);
      lb0_q <= merge(lb0_q, reg_wdata, hit_lb0, MASK_LB0);
      bwsrc_q <= merge(bwsrc_q, reg_wdata, hit_bwsrc, MASK_BWSRC);
    end
  end

  // ==========================================================
  // Read path
  // Done status is live inverse of busy, so writes to it have no effect
  wire logic cal_done = ~cal_busy;
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      OFF_ARB: rd_mux = {6'h00, cal_done, arb_q[ARB_BIT]};
      OFF_CAL: rd_mux = cal_q;
      OFF_POST1: rd_mux = post1_q;
      OFF_POST2: rd_mux = post2_q;
      OFF_PRE1: rd_mux = pre1_q;
      OFF_PRE2: rd_mux = pre2_q;
      OFF_SWING: rd_mux = swing_q;
      OFF_LB5: rd_mux = lb5_q;
      OFF_LB43: rd_mux = lb43_q;
      OFF_LB2: rd_mux = lb2_q;
      OFF_LB1: rd_mux = lb1_q;
      OFF_LB0: rd_mux = lb0_q;
      OFF_BWSRC: rd_mux = bwsrc_q;
      // Unmapped addresses read as zero
      default: rd_mux = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= RESET_VAL;
    end else begin
      rdata_q <= reg_read ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // Transmit equaliser and driver
  // First post-tap magnitude
  assign tx_ctrl.post1_mag = post1_q[4:0];
  assign tx_ctrl.post1_neg = post1_q[POST1_SIGN_BIT];
  assign tx_ctrl.post2_neg = post2_q[POST2_SIGN_BIT];
  assign tx_ctrl.pre1_neg = pre1_q[PRE1_SIGN_BIT];
  assign tx_ctrl.pre2_neg = pre2_q[PRE2_SIGN_BIT];
  assign tx_ctrl.post2_mag = post2_q[3:0];
  assign tx_ctrl.pre1_mag = pre1_q[4:0];
  assign tx_ctrl.pre2_mag = pre2_q[2:0];
  assign tx_ctrl.swing = swing_q[4:0];
  // Compensation costs power but cuts supply jitter
  assign tx_ctrl.hs_comp = swing_q[COMP_BIT];

  // ==========================================================
  // Loopback
  // Assemble selection, most significant first
  wire logic [5:0] lb_sel = {lb5_q[LB5_BIT], lb43_q[LB43_LSB+1], lb43_q[LB43_LSB],
                             lb2_q[LB2_BIT], lb1_q[LB1_BIT], lb0_q[LB0_BIT]};
  assign lb_ctrl.sel = lb_sel;
  // Diagnostic and post-recovery patterns; other codes leave both paths off
  assign lb_ctrl.diag_rev = (lb_sel == LB_DIAG);
  assign lb_ctrl.post_rev = (lb_sel == LB_POST);

  // ==========================================================
  // Calibration controls
  // Zero gives bus to user
  assign cal_ctrl.user_owns_bus = ~arb_q[ARB_BIT];
  assign cal_ctrl.engine_owns_bus = arb_q[ARB_BIT];
  assign cal_ctrl.rx_cal_en = cal_q[RXCAL_BIT];
  assign cal_ctrl.tx_cal_en = cal_q[TXCAL_BIT];
  assign cal_ctrl.reconfig_req = cal_q[PREP_BIT];
  assign cal_ctrl.bw_from_default = bwsrc_q[BWSRC_BIT];

  // ==========================================================
  // Checks
  // Each check restates a rule from the pins and the write data; the readback checks compare with stored post1_q and swing_q
  // Hold checks catch a stray decode landing on the wrong byte
  // Own address map, kept apart from the read mux so a slip there shows
  wire logic addr_mapped = (reg_addr == OFF_ARB) || (reg_addr == OFF_CAL) ||
    (reg_addr == OFF_POST1) || (reg_addr == OFF_POST2) || (reg_addr == OFF_PRE1) ||
    (reg_addr == OFF_PRE2) || (reg_addr == OFF_SWING) || (reg_addr == OFF_LB5) ||
    (reg_addr == OFF_LB43) || (reg_addr == OFF_LB2) || (reg_addr == OFF_LB1) ||
    (reg_addr == OFF_LB0) || (reg_addr == OFF_BWSRC);

  post1_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_post1 |=> tx_ctrl.post1_mag == $past(reg_wdata[4:0]))
    else $error("post tap1 magnitude not written");

  sign_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_post1 |=> tx_ctrl.post1_neg == $past(reg_wdata[POST1_SIGN_BIT]))
    else $error("post tap1 sign wrong");

  post2_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_post2 |=> tx_ctrl.post2_mag == $past(reg_wdata[3:0]) &&
      tx_ctrl.post2_neg == $past(reg_wdata[POST2_SIGN_BIT]))
    else $error("post tap2 not written");

  pre1_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_pre1 |=> tx_ctrl.pre1_mag == $past(reg_wdata[4:0]) &&
      tx_ctrl.pre1_neg == $past(reg_wdata[PRE1_SIGN_BIT]))
    else $error("pre tap1 not written");

  pre2_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_pre2 |=> tx_ctrl.pre2_mag == $past(reg_wdata[2:0]) &&
      tx_ctrl.pre2_neg == $past(reg_wdata[PRE2_SIGN_BIT]))
    else $error("pre tap2 not written");

  swing_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_swing |=> tx_ctrl.swing == $past(reg_wdata[4:0]) &&
      tx_ctrl.hs_comp == $past(reg_wdata[COMP_BIT]))
    else $error("swing or compensation not written");

  comp_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_swing |=> tx_ctrl.hs_comp == $past(reg_wdata[COMP_BIT]))
    else $error("compensation bit not written");

  lb_exclusive_a: assert property (@(posedge clock) disable iff (reset)
    !(lb_ctrl.diag_rev && lb_ctrl.post_rev))
    else $error("loopback paths both on");

  lb_off_a: assert property (@(posedge clock) disable iff (reset)
    lb_ctrl.sel == 6'b000000 |-> !lb_ctrl.diag_rev && !lb_ctrl.post_rev)
    else $error("loopback on with zero select");

  lb_top_a: assert property (@(posedge clock) disable iff (reset)
    hit_lb5 |=> lb_ctrl.sel[5] == $past(reg_wdata[LB5_BIT]))
    else $error("loopback select bit five wrong");

  lb_mid_a: assert property (@(posedge clock) disable iff (reset)
    hit_lb43 |=> lb_ctrl.sel[4:3] == $past(reg_wdata[5:4]))
    else $error("loopback select bits four and three wrong");

  lb_bit2_a: assert property (@(posedge clock) disable iff (reset)
    hit_lb2 |=> lb_ctrl.sel[2] == $past(reg_wdata[LB2_BIT]))
    else $error("loopback select bit two wrong");

  lb_bit1_a: assert property (@(posedge clock) disable iff (reset)
    hit_lb1 |=> lb_ctrl.sel[1] == $past(reg_wdata[LB1_BIT]))
    else $error("loopback select bit one wrong");

  lb_low_a: assert property (@(posedge clock) disable iff (reset)
    hit_lb0 |=> lb_ctrl.sel[0] == $past(reg_wdata[LB0_BIT]))
    else $error("loopback select bit zero wrong");

  lb_diag_a: assert property (@(posedge clock) disable iff (reset)
    lb_ctrl.diag_rev == (lb_ctrl.sel == 6'b100101))
    else $error("diagnostic loopback decode wrong");

  lb_post_a: assert property (@(posedge clock) disable iff (reset)
    lb_ctrl.post_rev == (lb_ctrl.sel == 6'b001010))
    else $error("post recovery loopback decode wrong");

  user_owner_a: assert property (@(posedge clock) disable iff (reset)
    hit_arb && !reg_wdata[ARB_BIT] |=> cal_ctrl.user_owns_bus)
    else $error("user not granted bus");

  owner_excl_a: assert property (@(posedge clock) disable iff (reset)
    cal_ctrl.user_owns_bus != cal_ctrl.engine_owns_bus)
    else $error("bus owned by both or neither");

  bus_owner_a: assert property (@(posedge clock) disable iff (reset)
    hit_arb |=> cal_ctrl.engine_owns_bus == $past(reg_wdata[ARB_BIT]) &&
      cal_ctrl.user_owns_bus != cal_ctrl.engine_owns_bus)
    else $error("bus ownership wrong");

  done_read_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && reg_addr == OFF_ARB |=> reg_rdata[DONE_BIT] == !$past(cal_busy))
    else $error("done bit not inverse of busy");

  cal_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_cal |=> {cal_ctrl.reconfig_req, cal_ctrl.tx_cal_en, cal_ctrl.rx_cal_en} ==
      {$past(reg_wdata[3]), $past(reg_wdata[1:0])})
    else $error("calibration enables not written");

  txcal_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_cal |=> cal_ctrl.tx_cal_en == $past(reg_wdata[TXCAL_BIT]))
    else $error("transmit calibration enable not written");

  prep_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_cal |=> cal_ctrl.reconfig_req == $past(reg_wdata[PREP_BIT]))
    else $error("reconfiguration request not written");

  bw_write_a: assert property (@(posedge clock) disable iff (reset)
    hit_bwsrc |=> cal_ctrl.bw_from_default == $past(reg_wdata[BWSRC_BIT]))
    else $error("bandwidth flag not written");

  bw_hold_a: assert property (@(posedge clock) disable iff (reset)
    !hit_bwsrc |=> $stable(cal_ctrl.bw_from_default))
    else $error("bandwidth flag changed without write");

  readback_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && reg_addr == OFF_POST1 |=> reg_rdata == $past(post1_q))
    else $error("readback mismatch");

  readback_swing_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && reg_addr == OFF_SWING |=> reg_rdata == $past(swing_q))
    else $error("swing readback mismatch");

  rdata_idle_a: assert property (@(posedge clock) disable iff (reset)
    !reg_read |=> reg_rdata == 8'h00)
    else $error("read data not zero when idle");

  unmapped_read_a: assert property (@(posedge clock) disable iff (reset)
    reg_read && !addr_mapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  tx_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(hit_post1 || hit_post2 || hit_pre1 || hit_pre2 || hit_swing) |=>
      $stable(tx_ctrl))
    else $error("transmit settings changed without write");

  cal_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(hit_arb || hit_cal || hit_bwsrc) |=> $stable(cal_ctrl))
    else $error("calibration controls changed without write");

  lb_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(hit_lb5 || hit_lb43 || hit_lb2 || hit_lb1 || hit_lb0) |=>
      $stable(lb_ctrl))
    else $error("loopback select changed without write");

endmodule : spmr_regs

/* verification/spmr_tb.sv */
// Self-checking testbench for the PMA settings register bank
`timescale 1ns/1ps
module testbench;
  import spmr_pkg::*;

  // ==========================================================
  // Signals
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic cal_busy = 1'b0;
  spmr_tx_s tx_ctrl;
  spmr_cal_s cal_ctrl;
  spmr_lb_s lb_ctrl;
  int err_total = 0;
  int n_checks = 0;
  logic [11:0] offs [13];
  logic [7:0] masks [13];
  logic [7:0] pats [2] = '{8'hA5, 8'h5A};
  logic [5:0] sels [5] = '{6'h00, 6'h25, 6'h0A, 6'h3F, 6'h24};
  logic [7:0] p;
  logic [5:0] s;

  always #10 clock = ~clock;

  spmr_regs spmr_regs_i (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .cal_busy(cal_busy), .tx_ctrl(tx_ctrl),
    .cal_ctrl(cal_ctrl), .lb_ctrl(lb_ctrl));

  // ==========================================================
  // Tasks
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
    @(posedge clock);
    #1;
    chk("reg_rdata idle", reg_rdata, 8'h00);
  endtask : rd

  task automatic wr_sel(input logic [5:0] v);
    wr(OFF_LB5, {7'h00, v[5]});
    wr(OFF_LB43, {2'h0, v[4:3], 4'h0});
    wr(OFF_LB2, {v[2], 7'h00});
    wr(OFF_LB1, {v[1], 7'h00});
    wr(OFF_LB0, {3'h0, v[0], 4'h0});
  endtask : wr_sel

  task automatic results();
    if (err_total == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge clock);
    err_total++;
    results();
  end

  // ==========================================================
  // Tests
  initial begin
    offs = '{OFF_ARB, OFF_CAL, OFF_POST1, OFF_POST2, OFF_PRE1, OFF_PRE2, OFF_SWING,
      OFF_LB5, OFF_LB43, OFF_LB2, OFF_LB1, OFF_LB0, OFF_BWSRC};
    masks = '{8'h01, 8'h0B, 8'h5F, 8'h2F, 8'h3F, 8'h17, 8'h3F,
      8'h01, 8'h30, 8'h80, 8'h80, 8'h10, 8'h80};
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    #1;
    chk("user_owns_bus", 8'(cal_ctrl.user_owns_bus), 8'h01);
    for (int i = 0; i < 13; i++) begin
      rd(offs[i], (i == 0) ? 8'h02 : 8'h00);
    end
    // Two opposite patterns catch swapped or stuck field bits
    for (int k = 0; k < 2; k++) begin
      p = pats[k];
      for (int i = 0; i < 13; i++) begin
        wr(offs[i], p);
      end
      chk("post1_mag", 8'(tx_ctrl.post1_mag), 8'(p[4:0]));
      chk("post1_neg", 8'(tx_ctrl.post1_neg), 8'(p[6]));
      chk("post2_mag", 8'(tx_ctrl.post2_mag), 8'(p[3:0]));
      chk("post2_neg", 8'(tx_ctrl.post2_neg), 8'(p[5]));
      chk("pre1_mag", 8'(tx_ctrl.pre1_mag), 8'(p[4:0]));
      chk("pre1_neg", 8'(tx_ctrl.pre1_neg), 8'(p[5]));
      chk("pre2_mag", 8'(tx_ctrl.pre2_mag), 8'(p[2:0]));
      chk("pre2_neg", 8'(tx_ctrl.pre2_neg), 8'(p[4]));
      chk("swing", 8'(tx_ctrl.swing), 8'(p[4:0]));
      chk("hs_comp", 8'(tx_ctrl.hs_comp), 8'(p[5]));
      chk("engine_owns_bus", 8'(cal_ctrl.engine_owns_bus), 8'(p[0]));
      chk("user_owns_bus", 8'(cal_ctrl.user_owns_bus), 8'(!p[0]));
      chk("rx_cal_en", 8'(cal_ctrl.rx_cal_en), 8'(p[0]));
      chk("tx_cal_en", 8'(cal_ctrl.tx_cal_en), 8'(p[1]));
      chk("reconfig_req", 8'(cal_ctrl.reconfig_req), 8'(p[3]));
      chk("bw_from_default", 8'(cal_ctrl.bw_from_default), 8'(p[7]));
      for (int i = 0; i < 13; i++) begin
        rd(offs[i], (p & masks[i]) | ((i == 0) ? 8'h02 : 8'h00));
      end
    end
    // Done bit follows busy live, and a write cannot set it
    wr(OFF_ARB, 8'hFF);
    @(posedge clock);
    cal_busy <= 1'b1;
    rd(OFF_ARB, 8'h01);
    @(posedge clock);
    cal_busy <= 1'b0;
    rd(OFF_ARB, 8'h03);
    // Read-modify-write keeps the neighbouring calibration fields
    rd(OFF_CAL, 8'h0A);
    wr(OFF_CAL, 8'h0A | 8'h01);
    chk("rx_cal_en rmw", 8'(cal_ctrl.rx_cal_en), 8'h01);
    chk("tx_cal_en rmw", 8'(cal_ctrl.tx_cal_en), 8'h01);
    chk("reconfig_req rmw", 8'(cal_ctrl.reconfig_req), 8'h01);
    for (int j = 0; j < 5; j++) begin
      s = sels[j];
      wr_sel(s);
      chk("lb_sel", 8'(lb_ctrl.sel), 8'(s));
      chk("diag_rev", 8'(lb_ctrl.diag_rev), 8'(s == 6'h25));
      chk("post_rev", 8'(lb_ctrl.post_rev), 8'(s == 6'h0A));
    end
    // Unmapped places, one aliasing the swing address in its low bits
    wr(12'h101, 8'hFF);
    wr(12'h209, 8'hFF);
    rd(12'h101, 8'h00);
    rd(OFF_SWING, 8'h1A);
    // Back-to-back reads with no gap
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= OFF_POST1;
    @(posedge clock);
    reg_addr <= OFF_SWING;
    #1;
    chk("reg_rdata first", reg_rdata, 8'h5A & 8'h5F);
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    chk("reg_rdata second", reg_rdata, 8'h1A);
    results();
  end

endmodule : testbench
